// ---- verilog/sar_adc_pkg.sv ----
// Shared constants, field positions and types of the converter control block.
// Assumes a 32-bit APB register bus and an analog front end outside the design.
package sar_adc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] ADDR_INPUT_SELECT   = 12'h000;
  localparam logic [11:0] ADDR_CONTROL_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RESULT_LOW     = 12'h008;
  localparam logic [11:0] ADDR_RESULT_HIGH    = 12'h00C;

  // Field positions in input_select_register.
  localparam int SEL_REF_HI   = 7;
  localparam int SEL_REF_LO   = 6;
  localparam int SEL_LEFT_ADJ = 5;
  localparam int SEL_CHAN_HI  = 4;

  // Field positions in converter_control_status.
  localparam int CS_ENABLE   = 7;
  localparam int CS_START    = 6;
  localparam int CS_FREE_RUN = 5;
  localparam int CS_DONE     = 4;
  localparam int CS_PRESC_HI = 2;

  // Reset values.
  localparam logic [7:0]  INPUT_SELECT_RESET = 8'h00;
  localparam logic [2:0]  PRESCALE_RESET     = 3'h0;
  localparam logic [31:0] PRDATA_RESET       = 32'h0000_0000;

  // Conversion timing in converter clock cycles.
  localparam int          RESULT_WIDTH  = 10;
  localparam logic [4:0]  CYCLES_NORMAL = 5'd13;
  localparam logic [4:0]  CYCLES_FIRST  = 5'd25;
  localparam logic [4:0]  SAR_LEAD      = 5'd11;
  localparam logic [9:0]  SAR_MSB       = 10'h200;

  // Converter clock divider: divide by (4 << prescale select).
  localparam logic [9:0]  PRESCALE_BASE = 10'h004;

  // Channel codes: last input pin, single-ended bandgap and ground, and the gain range.
  localparam logic [4:0]  CHAN_PIN_LAST = 5'h07;
  localparam logic [4:0]  CHAN_BANDGAP  = 5'h1E;
  localparam logic [4:0]  CHAN_GROUND   = 5'h1F;
  localparam logic [4:0]  CHAN_GAIN_LO  = 5'h08;
  localparam logic [4:0]  CHAN_GAIN_HI  = 5'h0F;
  localparam int          CHAN_GAIN_BIT = 1;

  // Reference choices.
  localparam logic [1:0]  REF_EXTERNAL = 2'b00;
  localparam logic [1:0]  REF_SUPPLY   = 2'b01;
  localparam logic [1:0]  REF_INTERNAL = 2'b11;

  typedef enum logic [1:0] {
    GAIN_1X   = 2'b00,
    GAIN_10X  = 2'b01,
    GAIN_200X = 2'b10
  } gain_t;

  typedef enum logic {
    ST_IDLE    = 1'b0,
    ST_CONVERT = 1'b1
  } conv_state_t;

endpackage

// ---- verilog/converter_clock_divider.sv ----
// Converter clock divider producing a one-cycle tick per converter clock period.
// Assumes run comes from logic on sys_clk; the count is cleared while run is low.
`timescale 1ns/1ps
module converter_clock_divider
  import sar_adc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] prescale_select,
  output logic            tick
);

  logic [9:0] count;
  wire  [9:0] terminal = (PRESCALE_BASE << prescale_select) - 10'h001;
  wire        at_end   = (count >= terminal);

  // The count runs only while enabled and is held at zero otherwise.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !run) begin
      count <= 10'h000;
      tick  <= 1'b0;
    end else begin
      count <= at_end ? 10'h000 : count + 10'h001;
      tick  <= at_end;
    end
  end

endmodule

// ---- verilog/sar_adc_control.sv ----
// Control logic of a 10-bit successive-approximation converter with APB registers.
// Assumes an analog front end that settles its comparator within one sys_clk cycle.
`timescale 1ns/1ps

// Operation
// - Result is a 10-bit unsigned code from ground to reference minus one step.
// - Reference field picks external pin, analog supply or internal 2.56V onto pin.
// - Channel field selects input and gain; pins, ground and bandgap are single ended.
// - Sixteen differential pairs; two pairs offer 1x, 10x, 200x gain.
// - Single-ended selections bypass the gain amplifier.
// - Selections act only while enabled; disabled converter is idle and unpowered.
// - Result right justified by default, left justified when left adjust set.
// - Reading the low byte blocks result updates.
// - A conversion finishing while blocked leaves both bytes and drops the result.
// - Reading the high byte releases the block.
// - Done flag rises at every completion, including dropped results.
// - Writing start one begins a conversion; start reads one until completion.
// - A channel change during a conversion applies in its last converter cycle.
// - Free-running mode converts continuously and updates results each time.
// - Free running continues whether or not the done flag is cleared.
// - Normal conversions last 13 converter cycles; the first after enable 25.
// - Converter clock divider counts only while enabled, held reset otherwise.
// - Completion writes result and sets flag together; single mode clears start.
// - Free running starts the next conversion right after completion.
module sar_adc_control
  import sar_adc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        comparator_in,
  output logic             analog_enable,
  output logic      [1:0]  reference_drive,
  output logic             internal_ref_drive,
  output logic      [4:0]  channel_select,
  output logic             gain_bypass,
  output gain_t            gain_select,
  output logic             sample_hold,
  output logic      [9:0]  dac_code,
  output logic             conversion_done_flag,
  output logic             conversion_active
);

  // Decodes the gain of a channel code; only the two gain pairs go above 1x.
  function automatic gain_t gain_of(input logic [4:0] code);
    gain_t g;
    g = GAIN_1X;
    if (code >= CHAN_GAIN_LO && code <= CHAN_GAIN_HI) begin
      g = code[CHAN_GAIN_BIT] ? GAIN_200X : GAIN_10X;
    end
    return g;
  endfunction

  // True for the input pins, ground and bandgap, which skip the gain stage.
  function automatic logic single_of(input logic [4:0] code);
    return (code <= CHAN_PIN_LAST) || (code == CHAN_BANDGAP) || (code == CHAN_GROUND);
  endfunction

  logic [7:0]        input_select;
  logic              converter_enable;
  logic              start_conversion;
  logic              free_running_select;
  logic [2:0]        clock_prescale_select;
  logic              first_pending;
  logic              conv_first;
  conv_state_t       state;
  logic [4:0]        adc_cycle;
  logic [9:0]        trial;
  logic [9:0]        mask;
  logic [9:0]        result;
  logic              lock;
  logic              comp_meta;
  logic              comp_sync;
  logic              tick;

  // Bus decode and handshake; every access completes in its first access cycle.
  wire hit_select = (paddr == ADDR_INPUT_SELECT);
  wire hit_ctrl   = (paddr == ADDR_CONTROL_STATUS);
  wire hit_low    = (paddr == ADDR_RESULT_LOW);
  wire hit_high   = (paddr == ADDR_RESULT_HIGH);
  wire mapped     = hit_select | hit_ctrl | hit_low | hit_high;
  wire wr_access  = psel & penable & pwrite & mapped;
  wire rd_setup   = psel & ~penable & ~pwrite;
  wire wr_select  = wr_access & hit_select;
  wire wr_ctrl    = wr_access & hit_ctrl;
  wire rd_low     = rd_setup & hit_low;
  wire rd_high    = rd_setup & hit_high;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Sequencing terms of the conversion in progress.
  wire [4:0] conv_len    = conv_first ? CYCLES_FIRST : CYCLES_NORMAL;
  wire       converting  = (state == ST_CONVERT);
  wire       complete    = converting & tick & (adc_cycle == conv_len - 5'd1);
  wire       last_cycle  = converting & (adc_cycle == conv_len - 5'd1);
  wire       msb_load    = converting & tick & (adc_cycle == conv_len - SAR_LEAD - 5'd1);
  wire       sar_step    = converting & tick & (adc_cycle >= conv_len - SAR_LEAD)
                           & (adc_cycle <= conv_len - 5'd2);
  wire       start_tick  = ~converting & tick & start_conversion & converter_enable;
  wire       restart     = complete & free_running_select & start_conversion;
  wire       begin_conv  = start_tick | restart;

  // Control register next values written by software.
  wire       next_enable = wr_ctrl ? pwdata[CS_ENABLE] : converter_enable;
  wire       start_write = wr_ctrl & pwdata[CS_START] & pwdata[CS_ENABLE];
  wire       flag_clear  = wr_ctrl & pwdata[CS_DONE];

  // Read data presentation, left or right justified.
  wire       left_adj    = input_select[SEL_LEFT_ADJ];
  wire [7:0] low_byte    = left_adj ? {result[1:0], 6'h00} : result[7:0];
  wire [7:0] high_byte   = left_adj ? result[9:2] : {6'h00, result[9:8]};
  wire [7:0] ctrl_byte   = {converter_enable, start_conversion, free_running_select,
                            conversion_done_flag, 1'b0, clock_prescale_select};
  wire [7:0] read_byte   = hit_select ? input_select :
                           hit_ctrl   ? ctrl_byte    :
                           hit_low    ? low_byte     :
                           hit_high   ? high_byte    : 8'h00;

  converter_clock_divider u_divider (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .run             (converter_enable),
    .prescale_select (clock_prescale_select),
    .tick            (tick)
  );

  // Comparator input from the analog side passes two flip-flops.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comparator_in;
      comp_sync <= comp_meta;
    end
  end

  // Software writes of the selection and configuration fields.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      input_select          <= INPUT_SELECT_RESET;
      converter_enable      <= 1'b0;
      free_running_select   <= 1'b0;
      clock_prescale_select <= PRESCALE_RESET;
    end else begin
      if (wr_select) begin
        input_select <= pwdata[7:0];
      end
      if (wr_ctrl) begin
        converter_enable      <= pwdata[CS_ENABLE];
        free_running_select   <= pwdata[CS_FREE_RUN];
        clock_prescale_select <= pwdata[CS_PRESC_HI:0];
      end
    end
  end

  // Start bit: a one starts, a zero is ignored, completion clears it in single mode.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !next_enable) begin
      start_conversion <= 1'b0;
    end else if (start_write) begin
      start_conversion <= 1'b1;
    end else if (complete && !free_running_select) begin
      start_conversion <= 1'b0;
    end
  end

  // Done flag: a completion in the same cycle as a clear keeps the flag set.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
    end else begin
      conversion_done_flag <= complete | (conversion_done_flag & ~flag_clear);
    end
  end

  // The first conversion after enabling takes the long initialisation length.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !next_enable) begin
      first_pending <= 1'b0;
    end else if (!converter_enable) begin
      first_pending <= 1'b1;
    end else if (start_tick) begin
      first_pending <= 1'b0;
    end
  end

  // Conversion sequencer counting converter clock cycles.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !converter_enable) begin
      state      <= ST_IDLE;
      adc_cycle  <= 5'd0;
      conv_first <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_tick) begin
            state      <= ST_CONVERT;
            adc_cycle  <= 5'd0;
            conv_first <= first_pending;
          end
        end
        ST_CONVERT: begin
          if (restart) begin
            adc_cycle  <= 5'd0;
            conv_first <= 1'b0;
          end else if (complete) begin
            state <= ST_IDLE;
          end else if (tick) begin
            adc_cycle <= adc_cycle + 5'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Successive approximation: keep a trial bit when the input is at or above it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trial <= 10'h000;
      mask  <= 10'h000;
    end else if (msb_load) begin
      trial <= SAR_MSB;
      mask  <= SAR_MSB;
    end else if (sar_step) begin
      trial <= (comp_sync ? trial : (trial & ~mask)) | (mask >> 1);
      mask  <= mask >> 1;
    end
  end

  // Sample-and-hold is open from the start until the first trial bit.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !converter_enable) begin
      sample_hold <= 1'b0;
    end else if (begin_conv) begin
      sample_hold <= 1'b1;
    end else if (msb_load || complete) begin
      sample_hold <= 1'b0;
    end
  end

  // Result store; a low-byte read in this very cycle already blocks the update.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result <= 10'h000;
    end else if (complete && !lock && !rd_low) begin
      result <= trial;
    end
  end

  // Coherence lock between the two result byte reads.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock <= 1'b0;
    end else if (rd_high) begin
      lock <= 1'b0;
    end else if (rd_low) begin
      lock <= 1'b1;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= PRDATA_RESET;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

  // Applied selections follow software while idle, in the last cycle, and only when enabled.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !converter_enable) begin
      reference_drive    <= REF_EXTERNAL;
      internal_ref_drive <= 1'b0;
      channel_select     <= 5'h00;
      gain_bypass        <= 1'b1;
      gain_select        <= GAIN_1X;
    end else if (!converting || last_cycle) begin
      reference_drive    <= input_select[SEL_REF_HI:SEL_REF_LO];
      internal_ref_drive <= (input_select[SEL_REF_HI:SEL_REF_LO] == REF_INTERNAL);
      channel_select     <= input_select[SEL_CHAN_HI:0];
      gain_bypass        <= single_of(input_select[SEL_CHAN_HI:0]);
      gain_select        <= gain_of(input_select[SEL_CHAN_HI:0]);
    end
  end

  // Status outputs.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      analog_enable     <= 1'b0;
      conversion_active <= 1'b0;
      dac_code          <= 10'h000;
    end else begin
      analog_enable     <= converter_enable;
      conversion_active <= converting;
      dac_code          <= trial;
    end
  end

  // Helper count of converter ticks within one conversion, read only by checks.
  logic [7:0] ticks_seen;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || begin_conv) begin
      ticks_seen <= 8'h00;
    end else if (converting && tick) begin
      ticks_seen <= ticks_seen + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_finish;
    complete;
  endsequence

  sequence s_single_finish;
    complete && !free_running_select && !start_write;
  endsequence

  a_done_flag_set: assert property (s_finish |=> conversion_done_flag)
    else $error("done flag not set after completion");
  a_single_start_clear: assert property (s_single_finish |=> !start_conversion)
    else $error("start bit not cleared after single conversion");
  a_free_run_restart: assert property (s_finish ##0 restart |=> converting && adc_cycle == 5'd0
                                       && sample_hold)
    else $error("free running conversion did not restart");
  a_locked_result: assert property (s_finish ##0 lock |=> $stable(result))
    else $error("result changed while locked");
  a_low_read_lock: assert property (rd_low && !rd_high |=> lock [*1] ##0 $stable(result))
    else $error("low byte read did not lock results");
  a_high_read_free: assert property (rd_high |=> !lock)
    else $error("high byte read did not release lock");
  a_disabled_quiet: assert property (!converter_enable |=> !tick && !converting
                                     && !analog_enable)
    else $error("converter active while disabled");
  a_conv_length: assert property (s_finish |-> ticks_seen == (conv_first ? 8'd24 : 8'd12))
    else $error("conversion length wrong");
  a_channel_held: assert property (converting && !last_cycle && converter_enable
                                   |=> $stable(channel_select))
    else $error("channel changed during conversion");
  a_zero_start_kept: assert property (wr_ctrl && !pwdata[CS_START] && pwdata[CS_ENABLE]
                                      && start_conversion && !complete
                                      |=> start_conversion)
    else $error("writing zero cleared the start bit");
  a_bypass_single: assert property ($changed(channel_select) |-> gain_bypass ==
                                    single_of(channel_select))
    else $error("gain bypass does not match channel");

endmodule

// ---- bench/analog_front_model.sv ----
// Behavioural analog front end: gain stage, sample-hold and comparator.
// Assumes dac_code and sample_hold come from the control block on sys_clk.
`timescale 1ns/1ps
module analog_front_model
  import sar_adc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       analog_enable,
  input  wire logic       gain_bypass,
  input  wire gain_t      gain_select,
  input  wire logic       sample_hold,
  input  wire logic [9:0] vin,
  input  wire logic [9:0] dac_code,
  output logic            comparator_in
);
  logic [7:0]  factor;
  logic [17:0] amplified;
  logic [9:0]  held = 10'h000;
  logic        noise = 1'b0;
  // Only differential picks pass the gain stage; single-ended ones bypass it.
  assign factor = (gain_select == GAIN_200X) ? 8'hC8 : (gain_select == GAIN_10X) ? 8'h0A : 8'h01;
  assign amplified = gain_bypass ? {8'h00, vin} : vin * factor;
  // Tracks the input while the hold switch is open, clipped at full scale.
  always @(posedge sys_clk) begin
    if (sample_hold) begin
      held <= (amplified > 18'h0_03FF) ? 10'h3FF : amplified[9:0];
    end
    noise <= ~noise;
  end
  // The comparator answers only while powered; otherwise it chatters every cycle.
  assign comparator_in = analog_enable ? (held >= dac_code) : noise;
endmodule

// ---- bench/sar_adc_control_tb.sv ----
// Self-checking bench of the converter control block, driven over APB.
// Assumes the analog front end model of analog_front_model.sv beside it.
`timescale 1ns/1ps
module sar_adc_control_tb
  import sar_adc_pkg::*;
;
  localparam logic [31:0] EN = 32'h0000_0080;
  localparam logic [31:0] ST = 32'h0000_0040;
  localparam logic [31:0] FR = 32'h0000_0020;
  localparam logic [31:0] DN = 32'h0000_0010;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0]  vin = 10'h000;
  logic [31:0] prdata, q;
  logic        pready, pslverr, comparator_in, analog_enable, internal_ref_drive;
  logic        gain_bypass, sample_hold, conversion_done_flag, conversion_active, e;
  logic [1:0]  reference_drive;
  logic [4:0]  channel_select;
  logic [9:0]  dac_code;
  gain_t       gain_select;
  int          bad_count = 0;
  int          checked = 0;
  int          n;

  sar_adc_control dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_in(comparator_in), .analog_enable(analog_enable),
    .reference_drive(reference_drive), .internal_ref_drive(internal_ref_drive),
    .channel_select(channel_select), .gain_bypass(gain_bypass), .gain_select(gain_select),
    .sample_hold(sample_hold), .dac_code(dac_code),
    .conversion_done_flag(conversion_done_flag), .conversion_active(conversion_active));
  analog_front_model afe (.sys_clk(sys_clk), .analog_enable(analog_enable),
    .gain_bypass(gain_bypass), .gain_select(gain_select), .sample_hold(sample_hold),
    .vin(vin), .dac_code(dac_code), .comparator_in(comparator_in));

  // The system clock toggles every half period of 10 ns.
  always #10 sys_clk = ~sys_clk;

  // Prints the counts and the verdict, then stops the run.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer: setup, then access held until pready is sampled high.
  // An idle edge follows the release so that no strobe is driven twice in one step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Register write, register read with comparison, and plain cycle waits.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, q);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Writes the control word and counts cycles until the done flag shows.
  task automatic conv(input logic [31:0] ctl, output int k);
    wr(ADDR_CONTROL_STATUS, ctl);
    k = 0;
    while (conversion_done_flag !== 1'b1 && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    chk("done_flag", 1, conversion_done_flag);
  endtask

  // Reset values, unmapped access and selections held off while disabled.
  task automatic t_reset();
    rd(ADDR_INPUT_SELECT, 0, "input_select");
    rd(ADDR_CONTROL_STATUS, 0, "control_status");
    chk("gain_bypass_rst", 1, gain_bypass);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped_err", 1, e);
    chk("unmapped_data", 0, q);
    wr(ADDR_INPUT_SELECT, 32'h0000_00C3);
    wr(ADDR_CONTROL_STATUS, ST);
    cyc(3);
    chk("ref_off", 0, reference_drive);
    chk("chan_off", 0, channel_select);
    chk("active_off", 0, conversion_active);
    rd(ADDR_CONTROL_STATUS, 0, "start_ignored");
    rd(ADDR_INPUT_SELECT, 32'h0000_00C3, "sel_readback");
  endtask

  // Every channel code once and every reference code eight times, with the expected gain routing.
  task automatic t_select();
    logic [4:0] c;
    wr(ADDR_CONTROL_STATUS, EN);
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      wr(ADDR_INPUT_SELECT, {24'h00_0000, c[1:0], 1'b0, c});
      cyc(3);
      chk("channel", c, channel_select);
      chk("bypass", (c <= 5'h07 || c >= 5'h1E), gain_bypass);
      chk("gain", (c[4:3] != 2'b01) ? 0 : (c[1] ? 2 : 1), gain_select);
      chk("reference", c[1:0], reference_drive);
      chk("internal_ref", c[1:0] == 2'b11, internal_ref_drive);
    end
  endtask

  // First and normal conversion times, justification and start clearing.
  task automatic t_single();
    wr(ADDR_INPUT_SELECT, 0);
    vin <= 10'h2A5;
    conv(EN | ST, n);
    chk("first_time", 1, n >= 94 && n <= 108);
    rd(ADDR_CONTROL_STATUS, EN | DN, "start_cleared");
    rd(ADDR_RESULT_LOW, 32'h0000_00A5, "low_right");
    rd(ADDR_RESULT_HIGH, 32'h0000_0002, "high_right");
    wr(ADDR_INPUT_SELECT, 32'h0000_0020);
    vin <= 10'h1C7;
    conv(EN | ST | DN, n);
    chk("normal_time", 1, n >= 46 && n <= 60);
    rd(ADDR_RESULT_LOW, 32'h0000_00C0, "low_left");
    rd(ADDR_RESULT_HIGH, 32'h0000_0071, "high_left");
  endtask

  // A low-byte read locks the result until the high byte is read.
  task automatic t_lock();
    wr(ADDR_INPUT_SELECT, 0);
    vin <= 10'h155;
    conv(EN | ST | DN, n);
    rd(ADDR_RESULT_LOW, 32'h0000_0055, "low_before");
    vin <= 10'h0AA;
    conv(EN | ST | DN, n);
    rd(ADDR_RESULT_HIGH, 32'h0000_0001, "high_locked");
    conv(EN | ST | DN, n);
    rd(ADDR_RESULT_LOW, 32'h0000_00AA, "low_released");
    rd(ADDR_RESULT_HIGH, 32'h0000_0000, "high_released");
  endtask

  // Channel change and start-zero write in the middle of a conversion.
  task automatic t_midway();
    wr(ADDR_INPUT_SELECT, 32'h0000_0002);
    wr(ADDR_CONTROL_STATUS, EN | ST | DN);
    cyc(10);
    wr(ADDR_INPUT_SELECT, 32'h0000_0005);
    cyc(3);
    chk("chan_held", 32'h0000_0002, channel_select);
    wr(ADDR_CONTROL_STATUS, EN);
    cyc(2);
    chk("still_active", 1, conversion_active);
    rd(ADDR_CONTROL_STATUS, EN | ST, "start_kept");
    conv(EN, n);
    cyc(3);
    chk("chan_applied", 32'h0000_0005, channel_select);
  endtask

  // Free running ignores the done flag; disabling stops it and re-arms the long first.
  task automatic t_free();
    wr(ADDR_INPUT_SELECT, 0);
    vin <= 10'h300;
    conv(EN | ST | FR | DN, n);
    rd(ADDR_RESULT_LOW, 32'h0000_0000, "free_low");
    rd(ADDR_RESULT_HIGH, 32'h0000_0003, "free_high");
    vin <= 10'h0F0;
    cyc(130);
    rd(ADDR_CONTROL_STATUS, EN | ST | FR | DN, "free_status");
    rd(ADDR_RESULT_LOW, 32'h0000_00F0, "free_low2");
    rd(ADDR_RESULT_HIGH, 32'h0000_0000, "free_high2");
    conv(EN | ST | FR | DN, n);
    chk("free_period", 1, n <= 60);
    wr(ADDR_CONTROL_STATUS, 0);
    cyc(3);
    chk("idle_after_off", 0, conversion_active);
    chk("analog_off", 0, analog_enable);
    apb(1'b0, ADDR_CONTROL_STATUS, 32'h0000_0000);
    chk("start_off", 0, q[CS_START]);
    wr(ADDR_CONTROL_STATUS, EN | DN);
    conv(EN | ST, n);
    chk("refirst_time", 1, n >= 94 && n <= 108);
  endtask

  // Cuts a hung run short and counts it as a mismatch.
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end

  // Holds reset for three cycles, then runs the scenarios in turn.
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_select();
    t_single();
    t_lock();
    t_midway();
    t_free();
    final_report();
  end
endmodule
